// *** totalizer_pkg.sv ***
// package with constants of the totalizer and time service unit
package totalizer_pkg;
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_cmd = 8'h04;
  localparam logic [7:0] addr_load1 = 8'h08;
  localparam logic [7:0] addr_load2 = 8'h0C;
  localparam logic [7:0] addr_tot1 = 8'h10;
  localparam logic [7:0] addr_tot2 = 8'h14;
  localparam logic [7:0] addr_time_lo = 8'h18;
  localparam logic [7:0] addr_time_hi = 8'h1C;
  localparam logic [7:0] addr_status = 8'h20;
  localparam logic [7:0] addr_op_total = 8'h24;
  localparam logic [7:0] addr_op_powerup = 8'h28;
  localparam logic [7:0] addr_snap_temp = 8'h2C;
  localparam logic [7:0] addr_snap_batch = 8'h30;
  localparam logic [7:0] addr_link_err = 8'h34;
  localparam logic [7:0] addr_link_ok = 8'h38;
  localparam logic [7:0] addr_link_last = 8'h3C;
  localparam logic [7:0] addr_time_cyc = 8'h40;
  localparam logic [7:0] addr_link_frame = 8'h44;
  // ctrl field positions
  localparam int ctrl_dir1_pos = 0;
  localparam int ctrl_fail1_pos = 2;
  localparam int ctrl_dir2_pos = 4;
  localparam int ctrl_fail2_pos = 6;
  localparam int ctrl_pinrole_pos = 8;
  localparam logic [31:0] ctrl_reset = 32'h0000_0022;
  // status bit positions
  localparam int stat_unsync_pos = 0;
  localparam int stat_overheat_pos = 1;
  localparam int stat_batch_pos = 2;
  localparam int stat_running_pos = 3;
  // command codes
  localparam logic [3:0] cmd_clear = 4'h1;
  localparam logic [3:0] cmd_hold = 4'h2;
  localparam logic [3:0] cmd_cont = 4'h3;
  localparam logic [3:0] cmd_load = 4'h4;
  localparam logic [1:0] sel_t1 = 2'h1;
  localparam logic [1:0] sel_t2 = 2'h2;
  localparam logic [1:0] sel_both = 2'h3;
  // modes
  localparam logic [1:0] dir_reverse = 2'h0;
  localparam logic [1:0] dir_forward = 2'h1;
  localparam logic [1:0] dir_net = 2'h2;
  localparam logic [1:0] fail_run = 2'h0;
  localparam logic [1:0] fail_hold = 2'h1;
  localparam logic [1:0] fail_memory = 2'h2;
  localparam logic [3:0] pin_batch_a = 4'h5;
  localparam logic [3:0] pin_batch_b = 4'h6;
  // temperature thresholds in whole degrees C, signed
  localparam logic signed [15:0] temp_set_c = 16'sd85;
  localparam logic signed [15:0] temp_clear_c = 16'sd80;
  // timing
  localparam longint clock_hz = 100_000_000;
  localparam longint snapshot_ms = 330;
  localparam longint snapshot_cycles = clock_hz / 1000 * snapshot_ms;
  localparam longint hour_s = 3600;
  localparam longint hour_cycles = clock_hz * hour_s;
  localparam longint settle_s = 40;
  localparam longint settle_cycles = clock_hz * settle_s;
endpackage

// *** tot_if.sv ***
// interface carrying a command and flow increment to one totalizer
`timescale 1ns/1ps
`default_nettype none
interface tot_if;
  logic [3:0] cmd;
  logic cmd_valid;
  logic [31:0] load_value;
  logic [1:0] direction;
  logic [1:0] fail_mode;
  logic signed [31:0] increment;
  logic inc_valid;
  logic group_error;
  logic enable;
  logic [31:0] total;
  logic held;
  modport ctl (output cmd, cmd_valid, load_value, direction, fail_mode, increment,
    inc_valid, group_error, enable, input total, held);
  modport acc (input cmd, cmd_valid, load_value, direction, fail_mode, increment,
    inc_valid, group_error, enable, output total, held);
endinterface
`default_nettype wire

// *** totalizer_acc.sv ***
// one totalizer accumulator with clear, hold, continue and load
`timescale 1ns/1ps
`default_nettype none
module totalizer_acc
(
  input wire logic clock,
  input wire logic nrst,
  tot_if.acc port
);
  import totalizer_pkg::*;

  typedef struct packed {
    logic [31:0] total;
    logic held;
    logic signed [31:0] last_good;
  } acc_s;

  acc_s state_reg;
  acc_s state_next;

  // signed contribution of one increment after direction filtering
  function automatic logic signed [31:0] filt(input logic [1:0] d, input logic signed [31:0] v);
    logic signed [31:0] r;
    r = 32'sh0;
    if (d == dir_net)
      r = v;
    else if (d == dir_forward && v > 0)
      r = v;
    else if (d == dir_reverse && v < 0)
      r = -v;
    return r;
  endfunction

  // ==================================================================
  // next state
  always_comb
  begin
    logic signed [31:0] delta;
    delta = 32'sh0;
    state_next = state_reg;
    if (port.inc_valid && !port.group_error)
      state_next.last_good = port.increment;
    if (port.group_error)
    begin
      if (port.fail_mode == fail_run) // RL23
        delta = filt(port.direction, port.increment);
      else if (port.fail_mode == fail_memory)
        delta = filt(port.direction, state_reg.last_good);
    end
    else
      delta = filt(port.direction, port.increment); // RL22
    if (port.inc_valid && port.enable && !state_reg.held) // RL2 RL24
      state_next.total = state_reg.total + 32'(delta);
    if (port.cmd_valid)
    begin
      unique case (port.cmd)
        cmd_clear:
        begin
          state_next.total = 32'h0000_0000; // RL1
          state_next.held = 1'b0;
        end
        cmd_hold: state_next.held = 1'b1; // RL2
        cmd_cont: state_next.held = 1'b0; // RL3
        cmd_load:
        begin
          state_next.total = port.load_value; // RL4
          state_next.held = 1'b0;
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign port.total = state_reg.total;
  assign port.held = state_reg.held;

  hold_keeps_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg.held && !port.cmd_valid) |=> port.total == $past(port.total)) // RL2
    else $error("held totalizer changed");
  clear_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    (port.cmd_valid && port.cmd == cmd_clear) |=> port.total == 32'h0000_0000) // RL1
    else $error("clear did not zero");
  load_copy_a: assert property (@(posedge clock) disable iff (!nrst)
    (port.cmd_valid && port.cmd == cmd_load) |=> port.total == $past(port.load_value)) // RL4
    else $error("load value not copied");
endmodule
`default_nettype wire

// *** totalizer_time_service_unit.sv ***
// top: totalizers, bcd clock record, operating time, service snapshot, link stats
//
// Overview of operation
// [RL1] clear command zeroes totalizer, then counts
// [RL2] hold command freezes totalizer value
// [RL3] continue resumes from kept value
// [RL4] load command copies load value, counts on
// [RL5] combined commands act on both totalizers
// [RL6] pin role 5 or 6: totalizer two batches
// [RL7] batching ignores totalizer two config, commands
// [RL8] eight byte bcd date and time record
// [RL9] last byte: ms units, weekday low nibble
// [RL10] startup loads saved time from nonvolatile store
// [RL11] no valid time: unsynced flag set
// [RL12] new time received clears unsynced flag
// [RL13] time also set by address plus word
// [RL14] host resets time after restart, periodically
// [RL15] lifetime and powerup hours counted hourly
// [RL16] lifetime hours persist, powerup hours restart
// [RL17] service snapshot refreshed every 330 ms
// [RL18] overheat error set above 85 C
// [RL19] overheat error cleared below 80 C
// [RL20] service information read only
// [RL21] link error and ok counts, last errors
// [RL22] direction: reverse, forward or net counting
// [RL23] fail mode: actual, zero or last good
// [RL24] totalizers halted during 40 s settling
// [RL25] bcd byte: tens high, units low
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module totalizer_time_service_unit
#(
  parameter longint snap_cycles = totalizer_pkg::snapshot_cycles,
  parameter longint hour_len = totalizer_pkg::hour_cycles,
  parameter longint settle_len = totalizer_pkg::settle_cycles
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [31:0] flow_inc1,
  input wire logic signed [31:0] flow_inc2,
  input wire logic flow_inc_valid,
  input wire logic group_error,
  input wire logic [3:0] din_cmd,
  input wire logic [1:0] din_sel,
  input wire logic din_valid,
  input wire logic [63:0] saved_time,
  input wire logic saved_time_valid,
  input wire logic [31:0] saved_hours,
  input wire logic signed [15:0] enclosure_temp,
  input wire logic parity_err,
  input wire logic framing_err,
  input wire logic crc_err,
  input wire logic msg_ok,
  input wire logic coil_err,
  input wire logic holdreg_err,
  input wire logic [15:0] err_addr,
  input wire logic [7:0] err_no,
  output logic clock_unsynced_flag,
  output logic enclosure_overheat_error,
  output logic [31:0] hours_store,
  output logic hours_store_write
);
  import totalizer_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] load1;
    logic [31:0] load2;
    logic [63:0] clock_record;
    logic unsynced;
    logic boot_done;
    logic [31:0] op_total;
    logic [31:0] op_powerup;
    logic [47:0] hour_cnt;
    logic [47:0] snap_cnt;
    logic [47:0] settle_cnt;
    logic running;
    logic overheat;
    logic signed [15:0] snap_temp;
    logic [31:0] snap_batch;
    logic [31:0] snap_tot2_prev;
    logic [15:0] parity_cnt;
    logic [15:0] framing_cnt;
    logic [15:0] crc_cnt;
    logic [31:0] ok_cnt;
    logic [15:0] coil_addr;
    logic [7:0] coil_no;
    logic [15:0] holdreg_addr;
    logic [7:0] holdreg_no;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] hours_store;
    logic hours_store_write;
  } top_s;

  top_s state_reg;
  top_s state_next;

  tot_if t1 ();
  tot_if t2 ();

  // ==================================================================
  // totalizer instances
  totalizer_acc u_tot1
  (
    .clock(clock),
    .nrst(nrst),
    .port(t1)
  );
  totalizer_acc u_tot2
  (
    .clock(clock),
    .nrst(nrst),
    .port(t2)
  );

  // saturating 16-bit increment for error counters
  function automatic logic [15:0] bump16(input logic [15:0] v, input logic en);
    logic [15:0] r;
    r = v;
    if (en && v != 16'hFFFF)
      r = v + 16'h0001;
    return r;
  endfunction

  // tells whether the command selector addresses a given totalizer
  function automatic logic hits(input logic [1:0] sel, input logic [1:0] which);
    return (sel == which) || (sel == sel_both); // RL5
  endfunction

  // ==================================================================
  // decodes and wiring to the totalizers
  logic batching;
  logic apb_wr;
  logic apb_rd;
  logic host_cmd;
  logic [3:0] cmd_code;
  logic [1:0] cmd_sel;
  logic [3:0] pin_role;

  assign pin_role = state_reg.ctrl[ctrl_pinrole_pos +: 4];
  assign batching = (pin_role == pin_batch_a) || (pin_role == pin_batch_b); // RL6
  assign apb_wr = psel && penable && pwrite && !state_reg.pready;
  assign apb_rd = psel && penable && !pwrite && !state_reg.pready;
  assign host_cmd = apb_wr && paddr == addr_cmd;
  assign cmd_code = host_cmd ? pwdata[3:0] : din_cmd;
  assign cmd_sel = host_cmd ? pwdata[5:4] : din_sel;

  // command routing: host bus wins over the digital input in the same cycle
  assign t1.cmd = cmd_code;
  assign t1.cmd_valid = (host_cmd || din_valid) && hits(cmd_sel, sel_t1); // RL5
  assign t1.load_value = state_reg.load1;
  assign t1.direction = state_reg.ctrl[ctrl_dir1_pos +: 2];
  assign t1.fail_mode = state_reg.ctrl[ctrl_fail1_pos +: 2];
  assign t1.increment = flow_inc1;
  assign t1.inc_valid = flow_inc_valid;
  assign t1.group_error = group_error;
  assign t1.enable = state_reg.running; // RL24
  assign t2.cmd = cmd_code;
  assign t2.cmd_valid = (host_cmd || din_valid) && hits(cmd_sel, sel_t2) && !batching; // RL7
  assign t2.load_value = state_reg.load2;
  // batching forces plain forward counting, ignoring configured modes
  assign t2.direction = batching ? dir_forward : state_reg.ctrl[ctrl_dir2_pos +: 2]; // RL7
  assign t2.fail_mode = batching ? fail_run : state_reg.ctrl[ctrl_fail2_pos +: 2]; // RL7
  assign t2.increment = flow_inc2;
  assign t2.inc_valid = flow_inc_valid;
  assign t2.group_error = group_error;
  assign t2.enable = state_reg.running;

  // ==================================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.hours_store_write = 1'b0;
    // power-up: restore time and lifetime hours once
    if (!state_reg.boot_done)
    begin
      state_next.boot_done = 1'b1;
      state_next.clock_record = saved_time_valid ? saved_time : 64'h0000_0000_0000_0000; // RL10
      state_next.unsynced = 1'b1; // RL11
      state_next.op_total = saved_hours; // RL16
      state_next.op_powerup = 32'h0000_0000; // RL16
    end
    // settling delay before counting starts
    if (!state_reg.running)
    begin
      if (state_reg.settle_cnt >= 48'(settle_len - 1))
        state_next.running = 1'b1; // RL24
      else
        state_next.settle_cnt = state_reg.settle_cnt + 48'h1;
    end
    // hourly operating time update
    if (state_reg.hour_cnt >= 48'(hour_len - 1))
    begin
      state_next.hour_cnt = 48'h0;
      state_next.op_total = state_reg.op_total + 32'h1; // RL15
      state_next.op_powerup = state_reg.op_powerup + 32'h1; // RL15
      state_next.hours_store = state_reg.op_total + 32'h1; // RL16
      state_next.hours_store_write = 1'b1;
    end
    else
      state_next.hour_cnt = state_reg.hour_cnt + 48'h1;
    // service snapshot refresh
    if (state_reg.snap_cnt >= 48'(snap_cycles - 1))
    begin
      state_next.snap_cnt = 48'h0;
      state_next.snap_temp = enclosure_temp; // RL17
      state_next.snap_batch = t2.total;
      if (enclosure_temp > temp_set_c)
        state_next.overheat = 1'b1; // RL18
      else if (enclosure_temp < temp_clear_c)
        state_next.overheat = 1'b0; // RL19
    end
    else
      state_next.snap_cnt = state_reg.snap_cnt + 48'h1;
    // serial link statistics
    state_next.parity_cnt = bump16(state_reg.parity_cnt, parity_err); // RL21
    state_next.framing_cnt = bump16(state_reg.framing_cnt, framing_err);
    state_next.crc_cnt = bump16(state_reg.crc_cnt, crc_err);
    if (msg_ok)
      state_next.ok_cnt = state_reg.ok_cnt + 32'h1;
    if (coil_err)
    begin
      state_next.coil_addr = err_addr; // RL21
      state_next.coil_no = err_no;
    end
    if (holdreg_err)
    begin
      state_next.holdreg_addr = err_addr;
      state_next.holdreg_no = err_no;
    end
    // apb writes; service and statistics addresses ignore writes
    if (apb_wr)
    begin
      state_next.pready = 1'b1;
      unique case (paddr)
        addr_ctrl: state_next.ctrl = pwdata;
        addr_cmd: ;
        addr_load1: state_next.load1 = pwdata;
        addr_load2: state_next.load2 = pwdata;
        addr_time_lo: state_next.clock_record[31:0] = pwdata; // RL8 RL9 RL25
        addr_time_hi:
        begin
          state_next.clock_record[63:32] = pwdata;
          state_next.unsynced = 1'b0; // RL12
        end
        addr_time_cyc:
        begin
          // cyclic channel: bit 0 picks the high or low record word, high half of the data replaces its upper 16 bits
          if (pwdata[0])
            state_next.clock_record[63:32] = {pwdata[31:16], state_reg.clock_record[47:32]};
          else
            state_next.clock_record[31:0] = {pwdata[31:16], state_reg.clock_record[15:0]};
          state_next.unsynced = 1'b0; // RL13
        end
        addr_status, addr_op_total, addr_op_powerup, addr_snap_temp, addr_snap_batch,
        addr_link_err, addr_link_frame, addr_link_ok, addr_link_last, addr_tot1,
        addr_tot2: ; // RL20
        default: state_next.pslverr = 1'b1;
      endcase
    end
    // apb reads
    if (apb_rd)
    begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h0000_0000;
      unique case (paddr)
        addr_ctrl: state_next.prdata = state_reg.ctrl;
        addr_cmd: ;
        addr_load1: state_next.prdata = state_reg.load1;
        addr_load2: state_next.prdata = state_reg.load2;
        addr_tot1: state_next.prdata = t1.total;
        addr_tot2: state_next.prdata = t2.total; // RL6
        addr_time_lo: state_next.prdata = state_reg.clock_record[31:0];
        addr_time_hi: state_next.prdata = state_reg.clock_record[63:32];
        addr_time_cyc: ;
        addr_status:
        begin
          state_next.prdata[stat_unsync_pos] = state_reg.unsynced;
          state_next.prdata[stat_overheat_pos] = state_reg.overheat;
          state_next.prdata[stat_batch_pos] = batching;
          state_next.prdata[stat_running_pos] = state_reg.running;
        end
        addr_op_total: state_next.prdata = state_reg.op_total;
        addr_op_powerup: state_next.prdata = state_reg.op_powerup;
        addr_snap_temp: state_next.prdata = {{16{state_reg.snap_temp[15]}}, state_reg.snap_temp};
        addr_snap_batch: state_next.prdata = state_reg.snap_batch;
        addr_link_err: state_next.prdata = {state_reg.crc_cnt, state_reg.parity_cnt};
        addr_link_frame: state_next.prdata = {16'h0000, state_reg.framing_cnt}; // RL21
        addr_link_ok: state_next.prdata = state_reg.ok_cnt;
        addr_link_last: state_next.prdata = {state_reg.coil_addr[7:0], state_reg.coil_no,
          state_reg.holdreg_addr[7:0], state_reg.holdreg_no};
        default: state_next.pslverr = 1'b1;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= '0;
      state_reg.ctrl <= ctrl_reset;
      state_reg.unsynced <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign clock_unsynced_flag = state_reg.unsynced;
  assign enclosure_overheat_error = state_reg.overheat;
  assign hours_store = state_reg.hours_store;
  assign hours_store_write = state_reg.hours_store_write;

  // ==================================================================
  // checks
  unsync_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (apb_wr && paddr == addr_time_hi && state_reg.boot_done) |=> !clock_unsynced_flag) // RL12
    else $error("unsynced flag not cleared");
  batch_ignore_a: assert property (@(posedge clock) disable iff (!nrst)
    batching |-> !t2.cmd_valid) // RL7
    else $error("command reached batch totalizer");
  overheat_set_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg.snap_cnt == 48'(snap_cycles - 1) && enclosure_temp > temp_set_c)
    |=> enclosure_overheat_error) // RL18
    else $error("overheat not raised");
  overheat_hyst_a: assert property (@(posedge clock) disable iff (!nrst)
    (enclosure_overheat_error && enclosure_temp >= temp_clear_c) |=> enclosure_overheat_error) // RL19
    else $error("overheat cleared inside hysteresis");
  halt_settle_a: assert property (@(posedge clock) disable iff (!nrst)
    !state_reg.running |=> $stable(t1.total) || $past(t1.cmd_valid)) // RL24
    else $error("totalizer counted while settling");
endmodule
`default_nettype wire

// *** host_model.sv ***
// host controller model: apb master issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdata;
  logic rerr;
  // idle bus at time zero
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not keep its last value
  endtask
endmodule
`default_nettype wire

// *** totalizer_time_service_unit_bench.sv ***
// self-checking bench of the totalizer and time service unit
`timescale 1ns/1ps
`default_nettype none
module totalizer_time_service_unit_bench;
  import totalizer_pkg::*;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, hours_store, v, h;
  logic signed [31:0] flow_inc1, flow_inc2;
  logic flow_inc_valid, group_error, din_valid, msg_ok, unsync, heat, hsw;
  logic parity_err, framing_err, crc_err, coil_err, holdreg_err;
  logic [3:0] din_cmd;
  logic [1:0] din_sel;
  logic [15:0] err_addr;
  logic [7:0] err_no;
  logic signed [15:0] enclosure_temp;
  int err_count, n_checks, cycles;
  localparam logic [63:0] saved = 64'h2406_1513_4530_1233;
  localparam logic [31:0] saved_h = 32'h0000_0010;
  // ========================================
  // clock, timeout and instances
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cycle ceiling against hangs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  totalizer_time_service_unit #(.snap_cycles(10), .hour_len(50), .settle_len(20)) DUT (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flow_inc1(flow_inc1), .flow_inc2(flow_inc2), .flow_inc_valid(flow_inc_valid),
    .group_error(group_error), .din_cmd(din_cmd), .din_sel(din_sel), .din_valid(din_valid),
    .saved_time(saved), .saved_time_valid(1'b1), .saved_hours(saved_h),
    .enclosure_temp(enclosure_temp), .parity_err(parity_err), .framing_err(framing_err),
    .crc_err(crc_err), .msg_ok(msg_ok), .coil_err(coil_err), .holdreg_err(holdreg_err),
    .err_addr(err_addr), .err_no(err_no), .clock_unsynced_flag(unsync),
    .enclosure_overheat_error(heat), .hours_store(hours_store), .hours_store_write(hsw));
  // ========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0);
    v = host.rdata;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] s);
    wr(addr_cmd, {26'h0, s, c});
  endtask
  task automatic pulse(input logic signed [31:0] a, input logic signed [31:0] b);
    @(posedge clock);
    flow_inc1 <= a;
    flow_inc2 <= b;
    flow_inc_valid <= 1'b1;
    @(posedge clock);
    flow_inc_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic totals(input logic [31:0] e1, input logic [31:0] e2);
    rd(addr_tot1);
    check(v, e1);
    rd(addr_tot2);
    check(v, e2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ========================================
  // scenarios
  task automatic t_start();
    pulse(32'sd5, 32'sd5);
    totals(32'h0, 32'h0);
    check({31'h0, unsync}, 32'h1);
    rd(addr_ctrl);
    check(v, ctrl_reset);
    rd(addr_time_hi);
    check(v, saved[63:32]);
    $display("test start done");
  endtask
  task automatic t_time();
    wr(addr_time_lo, 32'h5959_9987);
    wr(addr_time_hi, 32'h2512_3123);
    check({31'h0, unsync}, 32'h0);
    rd(addr_time_lo);
    check(v, 32'h5959_9987);
    wr(addr_time_cyc, 32'h2601_0001);
    rd(addr_time_hi);
    check(v, 32'h2601_3123);
    $display("test time done");
  endtask
  task automatic t_tot();
    repeat (20) @(posedge clock);
    pulse(32'sd7, 32'sd9);
    cmd(cmd_clear, sel_both);
    totals(32'h0, 32'h0);
    pulse(32'sd3, 32'sd4);
    totals(32'd3, 32'd4);
    cmd(cmd_hold, sel_t1);
    pulse(32'sd3, 32'sd4);
    totals(32'd3, 32'd8);
    cmd(cmd_cont, sel_t1);
    pulse(32'sd3, 32'sd4);
    totals(32'd6, 32'd12);
    wr(addr_load1, 32'd100);
    wr(addr_load2, 32'd200);
    cmd(cmd_load, sel_both);
    pulse(-32'sd1, -32'sd2);
    totals(32'd99, 32'd198);
    wr(addr_ctrl, 32'h0000_0011);
    pulse(-32'sd5, 32'sd5);
    totals(32'd99, 32'd203);
    wr(addr_ctrl, 32'h0000_0026);
    group_error <= 1'b1;
    pulse(32'sd4, 32'sd4);
    group_error <= 1'b0;
    totals(32'd99, 32'd207);
    wr(addr_ctrl, 32'h0000_0028);
    pulse(-32'sd6, 32'sd1);
    group_error <= 1'b1;
    pulse(32'sd9, 32'sd1);
    group_error <= 1'b0;
    totals(32'd111, 32'd209);
    $display("test totalizer done");
  endtask
  task automatic t_batch();
    wr(addr_ctrl, 32'h0000_0522);
    rd(addr_status);
    check({31'h0, v[stat_batch_pos]}, 32'h1);
    cmd(cmd_clear, sel_t2);
    rd(addr_tot2);
    check(v, 32'd209);
    @(posedge clock);
    {din_cmd, din_sel, din_valid} <= {cmd_clear, sel_both, 1'b1};
    @(posedge clock);
    din_valid <= 1'b0;
    totals(32'h0, 32'd209);
    wr(addr_ctrl, 32'h0000_0622);
    rd(addr_status);
    check({31'h0, v[stat_batch_pos]}, 32'h1);
    wr(addr_ctrl, 32'h0000_0022);
    $display("test batch done");
  endtask
  task automatic t_heat();
    enclosure_temp <= 16'sd90;
    repeat (25) @(posedge clock);
    check({31'h0, heat}, 32'h1);
    enclosure_temp <= 16'sd82;
    repeat (25) @(posedge clock);
    check({31'h0, heat}, 32'h1);
    enclosure_temp <= 16'sd79;
    repeat (25) @(posedge clock);
    check({31'h0, heat}, 32'h0);
    rd(addr_snap_temp);
    check(v, 32'd79);
    rd(addr_snap_batch);
    check(v, 32'd209);
    $display("test heat done");
  endtask
  task automatic t_misc();
    wr(addr_tot1, 32'h0000_FFFF);
    rd(addr_tot1);
    check(v, 32'd0);
    wr(8'h80, 32'h1);
    check({31'h0, host.rerr}, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock);
      {msg_ok, crc_err, parity_err, framing_err} <= {2'b11, i != 0, i == 0};
      {coil_err, holdreg_err, err_addr, err_no} <= {i == 1, i == 2, 12'h0A1, i[3:0], 4'h3, i[3:0]};
      @(posedge clock);
      {msg_ok, crc_err, parity_err, framing_err, coil_err, holdreg_err} <= 6'h00;
    end
    rd(addr_link_ok);
    check(v, 32'd3);
    rd(addr_link_err);
    check(v, 32'h0003_0002);
    rd(addr_link_frame);
    check(v, 32'h0000_0001);
    rd(addr_link_last);
    check(v, 32'h1131_1232);
    do @(posedge clock); while (hsw !== 1'b1);
    rd(addr_op_powerup);
    h = v;
    check(hours_store, saved_h + h);
    rd(addr_op_total);
    check(v, saved_h + h);
    do @(posedge clock); while (hsw !== 1'b1);
    rd(addr_op_powerup);
    check(v, h + 32'd1);
    $display("test misc done");
  endtask
  // ========================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    flow_inc1 = 32'sd0;
    flow_inc2 = 32'sd0;
    flow_inc_valid = 1'b0;
    group_error = 1'b0;
    din_valid = 1'b0;
    msg_ok = 1'b0;
    {din_cmd, din_sel, parity_err, framing_err, crc_err, coil_err, holdreg_err} = 11'h000;
    {err_addr, err_no} = 24'h00_0000;
    enclosure_temp = 16'sd25;
    err_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_start();
    t_time();
    t_tot();
    t_batch();
    t_heat();
    t_misc();
    conclude();
  end
endmodule
`default_nettype wire
